// ===== inc/wdog_pkg.sv
/*
  Constants for the windowed keyed watchdog: register offsets, field
  positions, reset values, service words and the slow-tick divider.
  Assumes a 100 MHz system clock and a 32-bit APB slave.
*/
package wdog_pkg;
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_IRQ_ST  = 8'h04;
  localparam logic [7:0]  OFF_TIMEOUT = 8'h08;
  localparam logic [7:0]  OFF_WINDOW  = 8'h0C;
  localparam logic [7:0]  OFF_SERVICE = 8'h10;
  localparam logic [7:0]  OFF_SEED    = 8'h14;
  localparam logic [7:0]  OFF_EXADDR  = 8'h18;
  localparam logic [7:0]  OFF_COUNT   = 8'h1C;
  localparam logic [7:0]  OFF_IRQ_MSK = 8'h20;

  // Control bits
  localparam int CTRL_EN   = 0;
  localparam int CTRL_HLK  = 1;
  localparam int CTRL_ITR  = 2;
  localparam int CTRL_WND  = 3;
  localparam int CTRL_SMD0 = 4;
  localparam int CTRL_SMD1 = 5;
  localparam int CTRL_W    = 6;

  // Interrupt status bits
  localparam int ST_TIMEOUT = 0;
  localparam int ST_INVALID = 1;
  localparam int ST_W       = 2;

  localparam logic [31:0] TIMEOUT_RST = 32'h0000_0100;
  localparam logic [15:0] SEED_RST    = 16'h5C17;
  localparam logic [15:0] SVC_WORD_A  = 16'hA602;
  localparam logic [15:0] SVC_WORD_B  = 16'hB480;
  localparam logic [15:0] KEY_MUL     = 16'h0011;
  localparam logic [15:0] KEY_ADD     = 16'h0003;

  // Slow oscillator: nominal 128 kHz expressed as a tick from 100 MHz
  localparam int SYS_HZ       = 100_000_000;
  localparam int SLOW_HZ      = 128_000;
  localparam int SLOW_DIV     = SYS_HZ / SLOW_HZ;
  localparam logic [9:0] SLOW_DIV_M1 = 10'(SLOW_DIV - 1);

  typedef enum logic [1:0] {
    SVC_FIXED,
    SVC_KEYED,
    SVC_FIXADDR,
    SVC_INCADDR
  } svc_mode_t;
endpackage : wdog_pkg

// ===== core/windowed_keyed_watchdog.sv
/*
  Windowed keyed watchdog with APB register access, interrupt-first or
  immediate fault, four service methods and a hard lock.
  Assumes an APB master on clk_sys and a CPU fetch-address strobe on the
  same clock for the two execution-address service methods.
*/
// What this block does
// - On expiry the counter either raises the fault at once or, in interrupt-first mode, raises the interrupt and reloads.
// - In interrupt-first mode a second consecutive expiry without a valid service raises the fault.
// - Every valid service reloads the down counter with the timeout period.
// - The fixed sequence is the word A602h followed by B480h written to the service register.
// - In keyed mode a service write is accepted only if it equals the internally held key, and a new key is then formed.
// - The next key is the current key times 17 plus 3, kept to 16 bits.
// - In fixed-address mode execution at the stored address services, and that address cannot be written while enabled.
// - In incremental-address mode execution at the stored address services, and that address may be rewritten while running.
// - The counter advances only on the slow oscillator tick, whatever else is configured.
// - The enable bit starts the watchdog and the hard-lock bit locks the configuration, both set by software.
// - Once hard lock is set every write to the configuration registers is rejected.
// - The timeout register holds a full 32-bit reload period.
// - The control register reads back so software can confirm the watchdog is enabled.
// - The slow tick runs at a nominal 128 kHz derived from the system clock.
`timescale 1ns/1ps
`default_nettype none
module windowed_keyed_watchdog (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fetch_valid,
  input  wire logic [31:0] fetch_addr,
  output logic             irq,
  output logic             fault_out
);
  import wdog_pkg::*;

  logic [CTRL_W-1:0] ctrl_ff;
  logic [31:0]       timeout_ff;
  logic [31:0]       window_ff;
  logic [31:0]       count_ff;
  logic [15:0]       key_ff;
  logic [31:0]       exaddr_ff;
  logic [ST_W-1:0]   status_ff;
  logic [ST_W-1:0]   mask_ff;
  logic              seq_a_ff;
  logic              irq_pend_ff;
  logic              fault_ff;
  logic [9:0]        div_ff;
  logic [31:0]       rdata_ff;

  function automatic logic [15:0] next_key(input logic [15:0] k);
    logic [31:0] p;
    p = {16'h0000, k} * {16'h0000, KEY_MUL} + {16'h0000, KEY_ADD};
    return p[15:0];
  endfunction : next_key

  wire        acc       = psel & penable;
  wire        wr        = acc & pwrite;
  wire        rd        = acc & ~pwrite;
  wire        enabled   = ctrl_ff[CTRL_EN];
  wire        locked    = ctrl_ff[CTRL_HLK];
  wire        irq_mode  = ctrl_ff[CTRL_ITR];
  wire        win_mode  = ctrl_ff[CTRL_WND];
  wire svc_mode_t mode  = svc_mode_t'(ctrl_ff[CTRL_SMD1:CTRL_SMD0]);
  wire        hit_ctrl  = paddr == OFF_CTRL;
  wire        hit_st    = paddr == OFF_IRQ_ST;
  wire        hit_to    = paddr == OFF_TIMEOUT;
  wire        hit_win   = paddr == OFF_WINDOW;
  wire        hit_svc   = paddr == OFF_SERVICE;
  wire        hit_seed  = paddr == OFF_SEED;
  wire        hit_exa   = paddr == OFF_EXADDR;
  wire        hit_cnt   = paddr == OFF_COUNT;
  wire        hit_msk   = paddr == OFF_IRQ_MSK;
  wire        mapped    = hit_ctrl | hit_st | hit_to | hit_win | hit_svc |
                          hit_seed | hit_exa | hit_cnt | hit_msk;
  wire        cfg_wr    = wr & ~locked;
  // The address register also stays frozen while enabled in fixed mode
  wire        exa_open  = ~locked & (mode == SVC_INCADDR | ~enabled);
  wire        slow_tick = div_ff == SLOW_DIV_M1;
  // Window opens once the count has fallen to the window value
  wire        win_open  = ~win_mode | (count_ff <= window_ff);
  wire        svc_wr    = wr & hit_svc & enabled;
  wire [15:0] svc_val   = pwdata[15:0];
  wire        fix_good  = mode == SVC_FIXED & svc_wr &
                          seq_a_ff & svc_val == SVC_WORD_B;
  wire        fix_first = mode == SVC_FIXED & svc_wr & svc_val == SVC_WORD_A;
  wire        fix_bad   = mode == SVC_FIXED & svc_wr & ~fix_first & ~fix_good;
  wire        key_good  = mode == SVC_KEYED & svc_wr & svc_val == key_ff;
  wire        key_bad   = mode == SVC_KEYED & svc_wr & ~key_good;
  wire        exe_hit   = enabled & fetch_valid & fetch_addr == exaddr_ff &
                          (mode == SVC_FIXADDR | mode == SVC_INCADDR);
  wire        svc_any   = fix_good | key_good | exe_hit;
  wire        svc_ok    = svc_any & win_open;
  // A wrong word always counts as a timeout; an early one only in windowed mode
  wire        svc_bad   = fix_bad | key_bad | (svc_any & ~win_open);
  wire        expire    = enabled & slow_tick & count_ff == 32'h0000_0000;
  wire        timeout   = expire | svc_bad;
  wire        to_fault  = timeout & (~irq_mode | irq_pend_ff);
  wire        to_irq    = timeout & irq_mode & ~irq_pend_ff;
  wire        st_clr    = rd & hit_st;

  wire [31:0] nxt_count = (svc_ok | to_irq | ~enabled) ? timeout_ff :
                          (slow_tick & count_ff != 32'h0000_0000) ? count_ff - 32'h0000_0001 :
                          count_ff;
  wire [ST_W-1:0] st_set = {svc_bad, expire};
  // A fresh event wins over the read that clears the status
  wire [ST_W-1:0] nxt_status = (st_clr ? {ST_W{1'b0}} : status_ff) | st_set;
  wire [31:0] rd_mux = hit_ctrl ? {26'h0, ctrl_ff} :
                       hit_st   ? {30'h0, status_ff} :
                       hit_to   ? timeout_ff :
                       hit_win  ? window_ff :
                       hit_seed ? {16'h0, key_ff} :
                       hit_exa  ? exaddr_ff :
                       hit_cnt  ? count_ff :
                       hit_msk  ? {30'h0, mask_ff} : 32'h0000_0000;

  assign pready    = 1'b1;
  assign pslverr   = acc & ~mapped;
  assign prdata    = rdata_ff;
  assign irq       = |(status_ff & mask_ff);
  assign fault_out = fault_ff;

  // Read data is registered, so it is loaded in the setup cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= 32'h0000_0000;
    end else if (psel & ~penable) begin
      rdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      div_ff <= 10'h000;
    end else begin
      div_ff <= slow_tick ? 10'h000 : div_ff + 10'h001;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff    <= '0;
      timeout_ff <= TIMEOUT_RST;
      window_ff  <= 32'h0000_0000;
      mask_ff    <= '0;
    end else if (cfg_wr) begin
      if (hit_ctrl) ctrl_ff <= pwdata[CTRL_W-1:0];
      if (hit_to) timeout_ff <= pwdata;
      if (hit_win) window_ff <= pwdata;
      if (hit_msk) mask_ff <= pwdata[ST_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      exaddr_ff <= 32'h0000_0000;
    end else if (wr & hit_exa & exa_open) begin
      exaddr_ff <= pwdata;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      key_ff <= SEED_RST;
    end else if (cfg_wr & hit_seed & ~enabled) begin
      key_ff <= pwdata[15:0];
    end else if (key_good & win_open) begin
      key_ff <= next_key(key_ff);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count_ff    <= TIMEOUT_RST;
      seq_a_ff    <= 1'b0;
      irq_pend_ff <= 1'b0;
      fault_ff    <= 1'b0;
      status_ff   <= '0;
    end else begin
      count_ff    <= nxt_count;
      // The first word is remembered until the next service write, so the
      // second word may arrive on a later APB access
      seq_a_ff    <= svc_wr ? fix_first : seq_a_ff;
      irq_pend_ff <= svc_ok ? 1'b0 : (to_irq ? 1'b1 : irq_pend_ff);
      fault_ff    <= fault_ff | to_fault;
      status_ff   <= nxt_status;
    end
  end

  a_fault_sticky: assert property (@(posedge clk_sys) disable iff (!resetn)
    fault_out |=> fault_out) else $error("fault dropped");
  a_lock_ctrl: assert property (@(posedge clk_sys) disable iff (!resetn)
    locked |=> $stable(ctrl_ff) && $stable(timeout_ff)) else $error("locked config changed");
  a_reload_svc: assert property (@(posedge clk_sys) disable iff (!resetn)
    svc_ok |=> count_ff == $past(timeout_ff)) else $error("service did not reload");
  a_first_irq: assert property (@(posedge clk_sys) disable iff (!resetn)
    expire && irq_mode && !irq_pend_ff |=> irq_pend_ff && count_ff == $past(timeout_ff)) else $error("no reload");
  a_direct_fault: assert property (@(posedge clk_sys) disable iff (!resetn)
    expire && !irq_mode |=> fault_out) else $error("no immediate fault");
  a_second_fault: assert property (@(posedge clk_sys) disable iff (!resetn)
    expire && irq_pend_ff |=> fault_out) else $error("no fault on second expiry");
  a_key_step: assert property (@(posedge clk_sys) disable iff (!resetn)
    key_good && win_open |=> key_ff == 16'($past(key_ff) * 17 + 3)) else $error("bad key step");
  a_fix_pair: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(seq_a_ff) |-> $past(fix_first)) else $error("pair armed wrongly");
  a_expire_flag: assert property (@(posedge clk_sys) disable iff (!resetn)
    expire |=> status_ff[ST_TIMEOUT]) else $error("expiry not flagged");
  a_svc_pend_clr: assert property (@(posedge clk_sys) disable iff (!resetn)
    svc_ok && !timeout |=> !irq_pend_ff) else $error("service left pending");
  a_bad_key: assert property (@(posedge clk_sys) disable iff (!resetn)
    key_bad |=> status_ff[ST_INVALID]) else $error("wrong key not flagged");
  a_key_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    enabled && !(key_good && win_open) |=> $stable(key_ff)) else $error("key moved");
  a_exa_lock: assert property (@(posedge clk_sys) disable iff (!resetn)
    locked |=> $stable(exaddr_ff)) else $error("locked address changed");
  a_early_bad: assert property (@(posedge clk_sys) disable iff (!resetn)
    svc_any && !win_open |=> status_ff[ST_INVALID]) else $error("early service not flagged");
  a_slow_count: assert property (@(posedge clk_sys) disable iff (!resetn)
    enabled && !slow_tick && !svc_any && !svc_bad |=> $stable(count_ff)) else $error("count moved off tick");
  a_exa_frozen: assert property (@(posedge clk_sys) disable iff (!resetn)
    enabled && mode == SVC_FIXADDR |=> $stable(exaddr_ff)) else $error("address changed");

  c_fix_service: cover property (@(posedge clk_sys) fix_good && win_open);
  c_key_service: cover property (@(posedge clk_sys) key_good && win_open);
  c_exec_service: cover property (@(posedge clk_sys) exe_hit);
  c_two_expiry: cover property (@(posedge clk_sys) expire && irq_pend_ff);
  c_early_service: cover property (@(posedge clk_sys) svc_any && !win_open);
endmodule : windowed_keyed_watchdog
`default_nettype wire

// ===== testbench/fault_collector.sv
/*
  Fault collection model: latches the watchdog fault line and counts interrupt rises.
  Assumes both lines are level outputs on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module fault_collector (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       fault_out,
  input  wire logic       irq,
  output logic            fault_seen_ff,
  output logic      [7:0] irq_rise_ff
);
  logic irq_d_ff;
  // Fault is kept until reset: the safe state needs no further action
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fault_seen_ff <= 1'b0;
      irq_rise_ff   <= 8'h00;
      irq_d_ff      <= 1'b0;
    end else begin
      irq_d_ff <= irq;
      if (fault_out) fault_seen_ff <= 1'b1;
      if (irq && !irq_d_ff) irq_rise_ff <= irq_rise_ff + 8'h01;
    end
  end
endmodule : fault_collector
`default_nettype wire

// ===== testbench/testbench.sv
/*
  Testbench: APB register tasks, service sequences and expiry checks.
  Assumes a zero-wait APB slave and a slow tick every 781 system cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import wdog_pkg::*;
  logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, fetch_valid, irq, fault_out, fault_seen;
  logic [7:0]  paddr, irq_rise;
  logic [31:0] pwdata, prdata, fetch_addr, rdata_v;
  logic        err_v;
  int fail_count, check_count, n;
  windowed_keyed_watchdog u_dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .irq(irq), .fault_out(fault_out));
  fault_collector u_fcu (.clk_sys(clk_sys), .resetn(resetn), .fault_out(fault_out), .irq(irq),
    .fault_seen_ff(fault_seen), .irq_rise_ff(irq_rise));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Starts right after an edge; keep leaves psel up for a back-to-back setup
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic keep);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys) penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdata_v = prdata;
    err_v   = pslverr;
    // With keep the next call lowers penable in its own setup
    if (!keep) begin
      penable <= 1'b0;
      psel <= 1'b0;
      @(posedge clk_sys);
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, 1'b0);
    chk(rdata_v, e);
  endtask : rd
  task automatic rst;
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
  endtask : rst
  initial begin
    #900_000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    fail_count = 0; check_count = 0;
    resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    fetch_valid = 1'b0; fetch_addr = 32'h0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd(OFF_CTRL, 32'h0000_0000);
    rd(OFF_TIMEOUT, TIMEOUT_RST);
    rd(OFF_SEED, {16'h0000, SEED_RST});
    apb(1'b0, 8'h24, 32'h0, 1'b0);
    chk({31'h0, err_v}, 32'h0000_0001);
    wr(OFF_TIMEOUT, 32'hFFFF_FFFF);
    rd(OFF_TIMEOUT, 32'hFFFF_FFFF);
    // Keyed service with interrupt first; a good service, a wrong key, two more good services, then two expiries to fault
    wr(OFF_TIMEOUT, 32'h0000_0004);
    wr(OFF_IRQ_MSK, 32'h0000_0003);
    wr(OFF_CTRL, 32'h0000_0015);
    rd(OFF_CTRL, 32'h0000_0015);
    repeat (800) @(posedge clk_sys);
    wr(OFF_SERVICE, 32'h0000_5C17);
    rd(OFF_COUNT, 32'h0000_0004);
    wr(OFF_SERVICE, 32'h0000_5C17);
    rd(OFF_IRQ_ST, 32'h0000_0002);
    wr(OFF_SERVICE, 32'h0000_1D8A);
    rd(OFF_COUNT, 32'h0000_0004);
    wr(OFF_SERVICE, 32'h0000_F62D);
    rd(OFF_COUNT, 32'h0000_0004);
    for (n = 0; n < 5000 && irq !== 1'b1; n++) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0000_0001);
    rd(OFF_IRQ_ST, 32'h0000_0001);
    #1 chk({31'h0, irq}, 32'h0000_0000);
    for (n = 0; n < 5000 && fault_out !== 1'b1; n++) @(posedge clk_sys);
    @(posedge clk_sys);
    chk({31'h0, fault_seen}, 32'h0000_0001);
    // Rises: wrong key, first expiry, second expiry
    chk({24'h0, irq_rise}, 32'h0000_0003);
    // Fixed pair, then immediate fault on expiry
    rst();
    wr(OFF_TIMEOUT, 32'h0000_0004);
    wr(OFF_CTRL, 32'h0000_0001);
    repeat (800) @(posedge clk_sys);
    apb(1'b1, OFF_SERVICE, 32'h0000_A602, 1'b1);
    apb(1'b1, OFF_SERVICE, 32'h0000_B480, 1'b0);
    rd(OFF_COUNT, 32'h0000_0004);
    for (n = 0; n < 5000 && fault_out !== 1'b1; n++) @(posedge clk_sys);
    @(posedge clk_sys);
    chk({31'h0, fault_seen}, 32'h0000_0001);
    chk({24'h0, irq_rise}, 32'h0000_0000);
    // Fixed address under hard lock
    rst();
    wr(OFF_TIMEOUT, 32'h0000_0004);
    wr(OFF_EXADDR, 32'h0000_1000);
    wr(OFF_CTRL, 32'h0000_0027);
    wr(OFF_EXADDR, 32'h0000_2000);
    rd(OFF_EXADDR, 32'h0000_1000);
    wr(OFF_TIMEOUT, 32'h0000_0009);
    rd(OFF_TIMEOUT, 32'h0000_0004);
    rd(OFF_CTRL, 32'h0000_0027);
    repeat (800) @(posedge clk_sys);
    fetch_valid <= 1'b1; fetch_addr <= 32'h0000_1000;
    @(posedge clk_sys) fetch_valid <= 1'b0;
    rd(OFF_COUNT, 32'h0000_0004);
    // Windowed incremental address: early service is invalid
    rst();
    wr(OFF_TIMEOUT, 32'h0000_0004);
    wr(OFF_WINDOW, 32'h0000_0001);
    wr(OFF_CTRL, 32'h0000_003D);
    wr(OFF_EXADDR, 32'h0000_3000);
    rd(OFF_EXADDR, 32'h0000_3000);
    fetch_valid <= 1'b1; fetch_addr <= 32'h0000_3000;
    @(posedge clk_sys) fetch_valid <= 1'b0;
    rd(OFF_IRQ_ST, 32'h0000_0002);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
